// [pin_monitor.sv]
`default_nettype none
// ==========================================================================
// Load on the timer output pin.
// It only listens: it counts edges and measures the last high pulse.
module pin_monitor (
  input wire logic clock,
  input wire logic reset,
  input wire logic timer_output_pin,
  output logic [15:0] rise_count,
  output logic [15:0] fall_count,
  output logic [15:0] high_width
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_level_reg;
  logic [15:0] run_length_reg;

  always_ff @(posedge clock) begin
    if (reset) begin
      last_level_reg <= 1'b0;
      run_length_reg <= 16'h0000;
      rise_count <= 16'h0000;
      fall_count <= 16'h0000;
      high_width <= 16'h0000;
    end else begin
      last_level_reg <= timer_output_pin;
      if (timer_output_pin && !last_level_reg) begin
        rise_count <= rise_count + 16'h0001;
        run_length_reg <= 16'h0001;
      end else if (timer_output_pin) begin
        run_length_reg <= run_length_reg + 16'h0001;
      end
      if (!timer_output_pin && last_level_reg) begin
        fall_count <= fall_count + 16'h0001;
        high_width <= run_length_reg;
      end
    end
  end
endmodule // pin_monitor
`default_nettype wire

// [second_timer_pwm_unit.sv]
// Chosen here: the APB interface to the registers.
`include "timer_pwm_consts.svh"
`default_nettype none
module second_timer_pwm_unit #(
  parameter int MAX_EXPONENT = 16
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic timer_output_pin,
  output logic irq
);

  // ========================================================================
  // Elaboration check.
  if (MAX_EXPONENT < 1 || MAX_EXPONENT > 16) begin : g_bad_exponent
    $error("MAX_EXPONENT must lie between 1 and 16");
  end

  // ========================================================================
  // Helpers.
  function automatic logic word_hit(input logic [7:0] addr, input logic [7:0] idx);
    word_hit = (addr == {idx[5:0], 2'b00});
  endfunction

  function automatic logic out_hit(input logic [7:0] addr, input logic [7:0] idx);
    out_hit = word_hit(addr, idx | `OUT_SPACE);
  endfunction

  // Exponents above the limit are clamped rather than wrapping to a short period.
  function automatic logic [MAX_EXPONENT:0] presc_limit(input logic [4:0] exponent);
    logic [4:0] e;
    e = (exponent > 5'(MAX_EXPONENT)) ? 5'(MAX_EXPONENT) : exponent;
    presc_limit = (MAX_EXPONENT+1)'((17'h1 << e) - 17'h1);
  endfunction

  // ========================================================================
  // State.
  timer_pwm_pkg::control_one_t ctrl_one_reg;
  timer_pwm_pkg::control_two_t ctrl_two_reg;
  timer_pwm_pkg::unit_state_t state_reg, state_next;
  timer_pwm_pkg::status_t status_view;
  logic mask_reg;
  logic [7:0] load_high_reg;
  logic [7:0] reload_high_reg;
  logic [15:0] reload_reg;
  logic [15:0] count_reg;
  logic [15:0] capture_reg;
  logic [MAX_EXPONENT:0] presc_reg;
  logic overflow_reg;
  logic pin_reg;
  logic pin_prev_reg;
  logic [`IRQ_WIDTH-1:0] irq_status_reg;
  logic [`IRQ_WIDTH-1:0] irq_enable_reg;
  logic [`IRQ_WIDTH-1:0] irq_events;
  logic [`IRQ_WIDTH-1:0] irq_clear;
  logic [31:0] rdata_next;
  logic mapped;
  logic access;
  logic wr_en;
  logic load_low_wr;
  logic reload_low_wr;
  logic released;
  logic release_next;
  logic stop_event;
  logic tick;
  logic wrap;
  logic rise;
  logic fall;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic irq_reg;

  // ========================================================================
  // Bus slave. The answer comes one cycle into the access phase; writes
  // land on the completing edge so a held request never acts twice.
  assign access = psel & penable & ~pready_reg;
  assign wr_en = psel & penable & pready_reg & pwrite;
  assign load_low_wr = wr_en & out_hit(paddr, `IDX_LOAD_LOW);
  assign reload_low_wr = wr_en & out_hit(paddr, `IDX_RELOAD_LOW);

  always_comb begin
    status_view = '0;
    status_view.overflow_flag = overflow_reg;
    status_view.pin_level = pin_reg;
    status_view.held_state_flag = released;
    status_view.running_flag = (state_reg == timer_pwm_pkg::UNIT_RUNNING);
  end

  always_comb begin
    rdata_next = '0;
    mapped = 1'b1;
    if (word_hit(paddr, `IDX_CTRL_ONE)) begin
      rdata_next[7:0] = ctrl_one_reg;
    end else if (word_hit(paddr, `IDX_CTRL_TWO)) begin
      rdata_next[7:0] = ctrl_two_reg;
    end else if (word_hit(paddr, `IDX_MASK_CTRL)) begin
      rdata_next[`MASK_BIT] = mask_reg;
    end else if (word_hit(paddr, `IDX_LIVE_HIGH)) begin
      rdata_next[7:0] = count_reg[15:8];
    end else if (word_hit(paddr, `IDX_LIVE_LOW)) begin
      rdata_next[7:0] = count_reg[7:0];
    end else if (word_hit(paddr, `IDX_STATUS)) begin
      rdata_next[7:0] = status_view;
    end else if (word_hit(paddr, `IDX_CAPT_HIGH)) begin
      rdata_next[7:0] = capture_reg[15:8];
    end else if (word_hit(paddr, `IDX_CAPT_LOW)) begin
      rdata_next[7:0] = capture_reg[7:0];
    end else if (word_hit(paddr, `IDX_IRQ_STATUS)) begin
      rdata_next[`IRQ_WIDTH-1:0] = irq_status_reg;
    end else if (word_hit(paddr, `IDX_IRQ_ENABLE)) begin
      rdata_next[`IRQ_WIDTH-1:0] = irq_enable_reg;
    end else if (out_hit(paddr, `IDX_LOAD_HIGH) || out_hit(paddr, `IDX_LOAD_LOW) ||
                 out_hit(paddr, `IDX_RELOAD_HIGH) || out_hit(paddr, `IDX_RELOAD_LOW) ||
                 word_hit(paddr, `IDX_IRQ_CLEAR)) begin
      rdata_next = '0;
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      pready_reg <= access;
      pslverr_reg <= access & ~mapped;
      if (access) begin
        prdata_reg <= rdata_next;
      end
    end
  end

  // ========================================================================
  // Software registers.
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_one_reg <= `CTRL_RESET;
      ctrl_two_reg <= `CTRL_RESET;
      mask_reg <= 1'b0;
      load_high_reg <= `LOAD_RESET;
      reload_high_reg <= `RELOAD_RESET;
      reload_reg <= {`RELOAD_RESET, `RELOAD_RESET};
      irq_enable_reg <= '0;
    end else if (wr_en) begin
      if (word_hit(paddr, `IDX_CTRL_ONE)) begin
        ctrl_one_reg <= pwdata[7:0];
      end
      if (word_hit(paddr, `IDX_CTRL_TWO)) begin
        ctrl_two_reg <= pwdata[7:0];
      end
      if (word_hit(paddr, `IDX_MASK_CTRL)) begin
        mask_reg <= pwdata[`MASK_BIT];
      end
      if (out_hit(paddr, `IDX_LOAD_HIGH)) begin
        load_high_reg <= pwdata[7:0];
      end
      if (out_hit(paddr, `IDX_RELOAD_HIGH)) begin
        reload_high_reg <= pwdata[7:0];
      end
      if (reload_low_wr) begin
        reload_reg <= {reload_high_reg, pwdata[7:0]};
      end
      if (word_hit(paddr, `IDX_IRQ_ENABLE)) begin
        irq_enable_reg <= pwdata[`IRQ_WIDTH-1:0];
      end
    end
  end

  // ========================================================================
  // Held, stopped and running.
  assign released = (state_reg != timer_pwm_pkg::UNIT_HELD);
  assign release_next = mask_reg ? released : ctrl_one_reg.hold_release_bit;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      timer_pwm_pkg::UNIT_HELD: begin
        if (release_next) begin
          state_next = ctrl_one_reg.run_bit ? timer_pwm_pkg::UNIT_RUNNING : timer_pwm_pkg::UNIT_STOPPED;
        end
      end
      timer_pwm_pkg::UNIT_STOPPED, timer_pwm_pkg::UNIT_RUNNING: begin
        if (!release_next) begin
          state_next = timer_pwm_pkg::UNIT_HELD;
        end else if (ctrl_one_reg.run_bit) begin
          state_next = timer_pwm_pkg::UNIT_RUNNING;
        end else begin
          state_next = timer_pwm_pkg::UNIT_STOPPED;
        end
      end
      default: begin
        state_next = timer_pwm_pkg::UNIT_HELD;
      end
    endcase
  end

  assign stop_event = (state_reg == timer_pwm_pkg::UNIT_RUNNING) &&
                      (state_next != timer_pwm_pkg::UNIT_RUNNING);

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= timer_pwm_pkg::UNIT_HELD;
    end else begin
      state_reg <= state_next;
    end
  end

  // ========================================================================
  // Prescaler, counter and capture. The divider restarts on every start so
  // the first count after a start always takes a full divided period.
  // A tick is held back in the cycle the run bit drops, so the captured value is the final count.
  assign tick = (state_reg == timer_pwm_pkg::UNIT_RUNNING) &&
                (state_next == timer_pwm_pkg::UNIT_RUNNING) &&
                (presc_reg == presc_limit(ctrl_two_reg.clock_divide_exponent));
  assign wrap = tick && (count_reg == 16'hffff);

  always_ff @(posedge clock) begin
    if (reset || state_reg != timer_pwm_pkg::UNIT_RUNNING || tick) begin
      presc_reg <= '0;
    end else begin
      presc_reg <= presc_reg + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset || state_reg == timer_pwm_pkg::UNIT_HELD) begin
      count_reg <= '0;
      overflow_reg <= 1'b0;
    end else begin
      if (load_low_wr) begin
        count_reg <= {load_high_reg, pwdata[7:0]};
      end else if (wrap) begin
        count_reg <= reload_reg;
      end else if (tick) begin
        count_reg <= count_reg + 16'h0001;
      end
      if (wrap) begin
        overflow_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      capture_reg <= '0;
    end else if (stop_event) begin
      capture_reg <= count_reg;
    end
  end

  // ========================================================================
  // Output waveform. A pulse lasts one divided period after each overflow.
  always_ff @(posedge clock) begin
    if (reset || state_reg == timer_pwm_pkg::UNIT_HELD || !ctrl_one_reg.pwm_select) begin
      pin_reg <= 1'b0;
    end else if (wrap) begin
      pin_reg <= ctrl_two_reg.waveform_select ? ~pin_reg : 1'b1;
    end else if (tick && !ctrl_two_reg.waveform_select) begin
      pin_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= pin_reg;
    end
  end

  assign rise = pin_reg & ~pin_prev_reg;
  assign fall = ~pin_reg & pin_prev_reg;

  // ========================================================================
  // Interrupts. A new event wins over a clear in the same cycle.
  always_comb begin
    irq_events = '0;
    irq_events[`IRQ_STOP] = stop_event & ctrl_one_reg.stop_irq_enable;
    irq_events[`IRQ_FALL] = fall & ctrl_one_reg.fall_irq_enable;
    irq_events[`IRQ_RISE] = rise & ctrl_one_reg.rise_irq_enable;
    irq_events[`IRQ_OVF] = wrap;
  end

  assign irq_clear = (wr_en && word_hit(paddr, `IDX_IRQ_CLEAR)) ? pwdata[`IRQ_WIDTH-1:0] : '0;

  always_ff @(posedge clock) begin
    if (reset) begin
      irq_status_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
      irq_reg <= |(irq_status_reg & irq_enable_reg);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign timer_output_pin = pin_reg;
  assign irq = irq_reg;

  // ========================================================================
  // Checks.
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  AST_TIMER_PIN_LOW: assert property (
    !ctrl_one_reg.pwm_select |=> !pin_reg
  ) else $error("output moved in timer mode");

  AST_STOP_IRQ: assert property (
    stop_event && ctrl_one_reg.stop_irq_enable |=> irq_status_reg[`IRQ_STOP]
  ) else $error("stop interrupt lost");

  AST_FALL_IRQ: assert property (
    fall && !ctrl_one_reg.fall_irq_enable && !irq_status_reg[`IRQ_FALL] |=> !irq_status_reg[`IRQ_FALL]
  ) else $error("fall interrupt while disabled");

  AST_RISE_IRQ: assert property (
    rise && ctrl_one_reg.rise_irq_enable |=> irq_status_reg[`IRQ_RISE]
  ) else $error("rise interrupt lost");

  AST_STOPPED_HOLDS: assert property (
    state_reg == timer_pwm_pkg::UNIT_STOPPED && !load_low_wr |=> $stable(count_reg)
  ) else $error("counter moved while stopped");

  AST_HELD_CLEARS: assert property (
    state_reg == timer_pwm_pkg::UNIT_HELD |=> count_reg == 16'h0000 && !overflow_reg
  ) else $error("unit not cleared while held");

  AST_SQUARE_TOGGLE: assert property (
    wrap && ctrl_two_reg.waveform_select && ctrl_one_reg.pwm_select && !stop_event |=> pin_reg != $past(pin_reg)
  ) else $error("square output missed toggle");

  AST_DIVIDE_FOUR: assert property (
    tick && ctrl_two_reg.clock_divide_exponent == 5'h02 ##1
    (state_reg == timer_pwm_pkg::UNIT_RUNNING && $stable(ctrl_two_reg))[*3] ##1
    (state_reg == timer_pwm_pkg::UNIT_RUNNING && state_next == timer_pwm_pkg::UNIT_RUNNING &&
    $stable(ctrl_two_reg)) |-> tick
  ) else $error("divide by four period wrong");

  AST_OVF_STICKY: assert property (
    overflow_reg && state_reg != timer_pwm_pkg::UNIT_HELD |=> overflow_reg
  ) else $error("overflow flag dropped");

  AST_STATUS_READ: assert property (
    access && !pwrite && word_hit(paddr, `IDX_STATUS) |=>
    prdata[2] == $past(pin_reg) && prdata[0] == $past(state_reg == timer_pwm_pkg::UNIT_RUNNING)
  ) else $error("status read wrong");

  AST_CAPTURE: assert property (
    stop_event |=> capture_reg == $past(count_reg)
  ) else $error("capture missed at stop");

  AST_LOAD_COMMIT: assert property (
    load_low_wr && state_reg != timer_pwm_pkg::UNIT_HELD |=>
    count_reg == {$past(load_high_reg), $past(pwdata[7:0])}
  ) else $error("count load not committed");

  AST_RELOAD_COMMIT: assert property (
    reload_low_wr |=> reload_reg == {$past(reload_high_reg), $past(pwdata[7:0])}
  ) else $error("reload not committed");

  AST_MASK_FREEZE: assert property (
    mask_reg |=> released == $past(released)
  ) else $error("set or reset acted while masked");

  AST_RELOAD_ON_WRAP: assert property (
    wrap && !load_low_wr && state_next != timer_pwm_pkg::UNIT_HELD |=> count_reg == $past(reload_reg)
  ) else $error("no reload after overflow");

endmodule // second_timer_pwm_unit
`default_nettype wire

// [second_timer_pwm_unit_tb_top.sv]
`include "timer_pwm_consts.svh"
`default_nettype none
module second_timer_pwm_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] load_high_idx = `OUT_SPACE + `IDX_LOAD_HIGH;
  localparam logic [7:0] load_low_idx = `OUT_SPACE + `IDX_LOAD_LOW;
  localparam logic [7:0] reload_high_idx = `OUT_SPACE + `IDX_RELOAD_HIGH;
  localparam logic [7:0] reload_low_idx = `OUT_SPACE + `IDX_RELOAD_LOW;
  logic clock, reset, psel, penable, pwrite, pready, pslverr, timer_output_pin, irq, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] rise_count, fall_count, high_width, r0;
  logic [7:0] zero_idx [9];
  int bad_count, checks_done;

  second_timer_pwm_unit u_dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_output_pin(timer_output_pin), .irq(irq));
  pin_monitor u_load (.clock(clock), .reset(reset), .timer_output_pin(timer_output_pin),
    .rise_count(rise_count), .fall_count(fall_count), .high_width(high_width));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ==========================================================================
  // Bus access and comparison.
  function automatic logic [7:0] ad(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask

  // The wait is bounded so a dead slave cannot hang the run.
  task automatic apb(input logic wr_n, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr_n;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 100);
    chk(32'(n < 100), 32'h1);
    if (n >= 100) begin
      end_of_test;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, ad(idx), {24'h000000, d});
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] want);
    apb(1'b0, ad(idx), 32'h0);
    chk({24'h0, q[7:0]}, {24'h0, want});
  endtask

  // Runs from zero for n idle cycles, then checks the captured count.
  task automatic span(input logic [4:0] ex, input int n, input int lo, input int hi);
    logic [7:0] cap;
    wr(load_high_idx, 8'h00);
    wr(load_low_idx, 8'h00);
    wr(`IDX_CTRL_TWO, {3'b000, ex});
    wr(`IDX_CTRL_ONE, 8'h05);
    repeat (n) @(posedge clock);
    wr(`IDX_CTRL_ONE, 8'h01);
    apb(1'b0, ad(`IDX_CAPT_LOW), 32'h0);
    cap = q[7:0];
    chk(32'((cap >= lo) && (cap <= hi)), 32'h1);
    rd(`IDX_LIVE_LOW, cap);
  endtask

  task automatic end_of_test;
    $display("checks_done %0d bad_count %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    end_of_test;
  end

  // ==========================================================================
  // Scenarios.
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bad_count = 0;
    checks_done = 0;
    zero_idx = '{`IDX_CTRL_ONE, `IDX_CTRL_TWO, `IDX_LIVE_HIGH, `IDX_LIVE_LOW, `IDX_STATUS,
      `IDX_CAPT_HIGH, `IDX_CAPT_LOW, reload_high_idx, `IDX_IRQ_STATUS};
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    foreach (zero_idx[i]) rd(zero_idx[i], 8'h00);
    chk({31'h0, timer_output_pin}, 32'h0);
    apb(1'b0, ad(8'h3f), 32'h0);
    chk({31'h0, e}, 32'h1);
    wr(load_high_idx, 8'h12);
    wr(load_low_idx, 8'h34);
    rd(`IDX_LIVE_HIGH, 8'h00);
    wr(`IDX_CTRL_ONE, 8'h01);
    rd(`IDX_STATUS, 8'h02);
    wr(load_high_idx, 8'h12);
    wr(load_low_idx, 8'h34);
    rd(`IDX_LIVE_HIGH, 8'h12);
    rd(`IDX_LIVE_LOW, 8'h34);
    wr(load_low_idx, 8'h56);
    repeat (20) @(posedge clock);
    rd(`IDX_LIVE_LOW, 8'h56);
    rd(`IDX_LIVE_HIGH, 8'h12);
    wr(`IDX_CTRL_ONE, 8'h05);
    rd(`IDX_STATUS, 8'h03);
    span(5'd0, 100, 111, 113);
    span(5'd2, 100, 24, 26);
    span(5'd3, 100, 11, 14);
    span(5'd16, 100, 0, 1);
    rd(`IDX_IRQ_STATUS, 8'h00);
    wr(reload_high_idx, 8'hff);
    wr(reload_low_idx, 8'hf0);
    wr(load_high_idx, 8'hff);
    wr(load_low_idx, 8'hf0);
    wr(`IDX_IRQ_ENABLE, 8'h0f);
    wr(`IDX_CTRL_TWO, 8'h20);
    wr(`IDX_CTRL_ONE, 8'hb5);
    repeat (100) @(posedge clock);
    wr(`IDX_CTRL_ONE, 8'hf1);
    chk({16'h0, high_width}, 32'h10);
    rd(`IDX_IRQ_STATUS, 8'h0f);
    chk({31'h0, irq}, 32'h1);
    rd(`IDX_STATUS, {4'h0, 1'b1, rise_count != fall_count, 2'b10});
    wr(`IDX_IRQ_CLEAR, 8'h0f);
    rd(`IDX_IRQ_STATUS, 8'h00);
    chk({31'h0, irq}, 32'h0);
    r0 = rise_count;
    wr(`IDX_CTRL_TWO, 8'h00);
    wr(`IDX_CTRL_ONE, 8'h85);
    repeat (100) @(posedge clock);
    wr(`IDX_CTRL_ONE, 8'h81);
    chk({16'h0, high_width}, 32'h1);
    chk(32'(rise_count > r0), 32'h1);
    r0 = rise_count;
    wr(`IDX_CTRL_ONE, 8'h05);
    repeat (100) @(posedge clock);
    wr(`IDX_CTRL_ONE, 8'h01);
    chk({16'h0, rise_count}, {16'h0, r0});
    rd(`IDX_STATUS, 8'h0a);
    wr(`IDX_MASK_CTRL, 8'h20);
    wr(`IDX_CTRL_ONE, 8'h00);
    rd(`IDX_STATUS, 8'h0a);
    wr(`IDX_MASK_CTRL, 8'h00);
    wr(`IDX_CTRL_ONE, 8'h00);
    rd(`IDX_STATUS, 8'h00);
    end_of_test;
  end
endmodule // second_timer_pwm_unit_tb_top
`default_nettype wire

// [timer_pwm_consts.svh]
// ==========================================================================
// Behaviour
// - Mode bit selects plain timer or PWM.
// - Stop interrupt only when its enable set.
// - Falling output edge interrupts when enabled.
// - Rising output edge interrupts when enabled.
// - Run bit low stops counter, high counts.
// - Hold-release bit low keeps unit reset.
// - Waveform bit picks pulse or square output.
// - Clock divided by two to prescale exponent; exponents above MAX_EXPONENT divide by two to MAX_EXPONENT.
// - Live count readable as high, low bytes.
// - Overflow flag sticks until next unit reset.
// - Status bit 2 shows output pin level.
// - Status bit 1 shows held or released.
// - Status bit 0 shows stopped or running.
// - Counter captured at stop, held till next.
// - Count load commits on low byte write.
// - Reload commits on low byte, resets ones.
// - Mask bit set blocks set and reset actions.
`ifndef TIMER_PWM_CONSTS_SVH
`define TIMER_PWM_CONSTS_SVH

// ==========================================================================
// Register indices; the byte address is four times the index.
`define IDX_MASK_CTRL 8'h0b
`define IDX_CTRL_ONE 8'h0c
`define IDX_CTRL_TWO 8'h0d
`define IDX_LIVE_HIGH 8'h1a
`define IDX_LIVE_LOW 8'h1b
`define IDX_STATUS 8'h1c
`define IDX_CAPT_HIGH 8'h1d
`define IDX_CAPT_LOW 8'h1e
`define OUT_SPACE 8'h20
`define IDX_LOAD_HIGH 8'h0b
`define IDX_LOAD_LOW 8'h0c
`define IDX_RELOAD_HIGH 8'h0d
`define IDX_RELOAD_LOW 8'h0e
`define IDX_IRQ_STATUS 8'h30
`define IDX_IRQ_CLEAR 8'h31
`define IDX_IRQ_ENABLE 8'h32

// ==========================================================================
// Reset values and bit positions.
`define CTRL_RESET 8'h00
`define LOAD_RESET 8'h00
`define RELOAD_RESET 8'hff
`define MASK_BIT 5
`define IRQ_STOP 0
`define IRQ_FALL 1
`define IRQ_RISE 2
`define IRQ_OVF 3
`define IRQ_WIDTH 4

`endif

// [timer_pwm_pkg.sv]
`default_nettype none
package timer_pwm_pkg;

  typedef struct packed {
    logic pwm_select;
    logic stop_irq_enable;
    logic fall_irq_enable;
    logic rise_irq_enable;
    logic spare_three;
    logic run_bit;
    logic spare_one;
    logic hold_release_bit;
  } control_one_t;

  typedef struct packed {
    logic [1:0] spare;
    logic waveform_select;
    logic [4:0] clock_divide_exponent;
  } control_two_t;

  typedef struct packed {
    logic [3:0] spare;
    logic overflow_flag;
    logic pin_level;
    logic held_state_flag;
    logic running_flag;
  } status_t;

  typedef enum logic [1:0] {
    UNIT_HELD,
    UNIT_STOPPED,
    UNIT_RUNNING
  } unit_state_t;

endpackage
`default_nettype wire
